// [design/cqcce_top.sv]
// line B control register with wake-up sequencer, and line A error flags
// assumes all event inputs come from framer logic on clk_sys
`timescale 1ns/1ns
// Operation
// - baud field codes fail, 4.8k, 38.4k, 230.4k
// - successful sequence stores detected baud rate
// - writing bit 5 starts automatic sequence when framer is on
// - success raises wake irq, clears bit 5
// - boost current limit during automatic pulse
// - success makes device period readable
// - failure: irq, clear bit 5, baud zero
// - writing bit 4 fires wake pulse now
// - after manual pulse go to receive
// - bit 4 clears when pulse completes
// - bit 3 empties the transmit queue
// - bit 2 empties the receive queue
// - timer arm arms; send or trigger starts
// - clearing arm stops the timer at once
// - send transmits queue, then back to receive
// - send bit clears itself
// - error flags read-only, zero, clear on read
// - failed line A transmission sets bit 7
// - armed timer, empty queue sets bit 6
// - received length mismatch sets bit 2
// - checksum mismatch sets bit 3
// - parity error sets flag, raises irq
module cqcce_top (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic regWrEn,  // register write strobe
	input wire logic regRdEn,  // register read request
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic regRdReady,  // read request can be taken
	output logic regRdValid,
	input wire logic regRdAck,  // consumer takes the answer
	output logic [7:0] regRdData,
	input wire logic framerOnB,
	input wire logic seqDoneB,  // detection finished pulse
	input wire logic seqOkB,
	input wire logic [1:0] seqRateB,
	input wire logic [7:0] seqPeriodB,
	input wire logic txQueueEmptyB,
	input wire logic triggerCmdB,
	output logic wakePulseB,
	output logic currentBoostB,
	output logic wakeDoneIrq,
	output logic txModeB,
	output logic [7:0] devicePeriodB,
	output logic txQueueClearB,
	output logic rxQueueClearB,
	output logic cycleTimerArmB,
	output logic cycleTimerRunB,
	output logic cycleTimerStartB,
	output logic sendStartB,
	input wire logic [7:0] errEventA,  // direct flag set pulses
	input wire logic cycleArmA,
	input wire logic txStartA,
	input wire logic txQueueEmptyA,
	input wire logic rxDoneA,
	input wire logic [7:0] rxCountA,
	input wire logic [7:0] rxExpectA,
	input wire logic rxMsgDoneA,
	input wire logic [5:0] rxSumCalcA,
	input wire logic [5:0] rxSumRecvA,
	input wire logic rxParityA,
	output logic rxErrIrqA
);
	localparam int WAKE_CNT_W_L = cqcce_pkg::WAKE_CNT_W;  // pulse counter width
	localparam logic [WAKE_CNT_W_L-1:0] WAKE_LAST = WAKE_CNT_W_L'(cqcce_pkg::WAKE_PULSE_CYC - 1);

	// refuse a pulse length the counter cannot hold
	if (cqcce_pkg::WAKE_PULSE_CYC >= (1 << WAKE_CNT_W_L)) begin : g_wakeCntChk
		$error("wake counter too narrow");
	end

	logic wrCtl;  // write hits line_b_control
	logic rdTake;  // read taken by buffer
	logic rdErr;  // flag read taken, clears flags
	logic [7:0] rdWord;
	logic bufInReady;

	assign wrCtl = regWrEn && regAddr == cqcce_pkg::OFS_LINE_B_CONTROL;
	assign rdTake = regRdEn && bufInReady;
	assign rdErr = rdTake && regAddr == cqcce_pkg::OFS_LINE_A_ERROR_FLAGS;

	cqcce_pkg::cqcce_wake_t wake_q, wake_d;  // sequencer state
	logic [WAKE_CNT_W_L-1:0] cnt_q, cnt_d;  // pulse length counter
	logic [1:0] baud_q, baud_d;
	logic [7:0] period_q, period_d;
	logic arm_q, arm_d;
	logic run_q, run_d;
	logic start_q, start_d;
	logic send_q, send_d;
	logic txMode_q, txMode_d;
	logic txClr_q, txClr_d;
	logic rxClr_q, rxClr_d;
	logic irq_q, irq_d;
	logic pulse_q, pulse_d;
	logic boost_q, boost_d;
	logic [7:0] flags_q, flags_d;
	logic [7:0] flagSet;
	logic parIrq_q, parIrq_d;

	// control next state; ones written start actions, zeros written clear the timer arm and load into the baud field
	always_comb begin
		wake_d = wake_q;
		cnt_d = cnt_q;
		baud_d = baud_q;
		period_d = period_q;
		irq_d = 1'b0;
		pulse_d = pulse_q;
		boost_d = boost_q;
		txMode_d = txMode_q;
		arm_d = arm_q;
		send_d = 1'b0;
		txClr_d = 1'b0;
		rxClr_d = 1'b0;
		start_d = 1'b0;
		run_d = run_q;
		if (wrCtl) begin
			baud_d = regWrData[cqcce_pkg::BIT_BAUD_RATE_B_HIGH:cqcce_pkg::BIT_BAUD_RATE_B_LOW];
			arm_d = regWrData[cqcce_pkg::BIT_CYCLE_TIMER_ARM_B];
			txClr_d = regWrData[cqcce_pkg::BIT_TX_QUEUE_CLEAR_B];
			rxClr_d = regWrData[cqcce_pkg::BIT_RX_QUEUE_CLEAR_B];
			send_d = regWrData[cqcce_pkg::BIT_SEND_MASTER_MSG_B];
		end
		// send puts the line in transmit; empty queue hands it back
		if (send_d) begin
			txMode_d = 1'b1;
		end else if (send_q == 1'b0 && txQueueEmptyB && wake_q == cqcce_pkg::WS_IDLE) begin
			txMode_d = 1'b0;
		end
		// timer: start needs the arm already set; a cleared arm wins
		if ((send_d && arm_q) || (triggerCmdB && arm_q)) begin
			start_d = 1'b1;
			run_d = 1'b1;
		end
		if (!arm_d) begin
			start_d = 1'b0;
			run_d = 1'b0;
		end
		unique case (wake_q)
			cqcce_pkg::WS_IDLE: begin
				// automatic sequence has priority when both bits are written with the framer on
				if (wrCtl && regWrData[cqcce_pkg::BIT_AUTO_WAKEUP_SEQ_B] && framerOnB) begin
					wake_d = cqcce_pkg::WS_AUTO_PULSE;
					cnt_d = WAKE_LAST;
					pulse_d = 1'b1;
					boost_d = 1'b1;
					txMode_d = 1'b1;
				end else if (wrCtl && regWrData[cqcce_pkg::BIT_MANUAL_WAKE_PULSE_B]) begin
					wake_d = cqcce_pkg::WS_MANUAL_PULSE;
					cnt_d = WAKE_LAST;
					pulse_d = 1'b1;
					txMode_d = 1'b1;
				end
			end
			cqcce_pkg::WS_AUTO_PULSE: begin
				if (cnt_q == '0) begin
					wake_d = cqcce_pkg::WS_AUTO_WAIT;
					pulse_d = 1'b0;
					boost_d = 1'b0;
					txMode_d = 1'b0;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
			cqcce_pkg::WS_AUTO_WAIT: begin
				// line-side detection reports; the result beats a software write
				if (seqDoneB) begin
					wake_d = cqcce_pkg::WS_IDLE;
					irq_d = 1'b1;
					if (seqOkB) begin
						baud_d = seqRateB;
						period_d = seqPeriodB;
					end else begin
						baud_d = cqcce_pkg::BAUD_DETECT_FAIL;
					end
				end
			end
			cqcce_pkg::WS_MANUAL_PULSE: begin
				if (cnt_q == '0) begin
					wake_d = cqcce_pkg::WS_IDLE;
					pulse_d = 1'b0;
					txMode_d = 1'b0;
				end else begin
					cnt_d = cnt_q - 1'b1;
				end
			end
		endcase
	end

	// control registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			wake_q <= cqcce_pkg::WS_IDLE;
			cnt_q <= '0;
			baud_q <= cqcce_pkg::RST_LINE_B_CONTROL[7:6];
			period_q <= 8'h00;
			arm_q <= 1'b0;
			run_q <= 1'b0;
			start_q <= 1'b0;
			send_q <= 1'b0;
			txMode_q <= 1'b0;
			txClr_q <= 1'b0;
			rxClr_q <= 1'b0;
			irq_q <= 1'b0;
			pulse_q <= 1'b0;
			boost_q <= 1'b0;
		end else begin
			wake_q <= wake_d;
			cnt_q <= cnt_d;
			baud_q <= baud_d;
			period_q <= period_d;
			arm_q <= arm_d;
			run_q <= run_d;
			start_q <= start_d;
			send_q <= send_d;
			txMode_q <= txMode_d;
			txClr_q <= txClr_d;
			rxClr_q <= rxClr_d;
			irq_q <= irq_d;
			pulse_q <= pulse_d;
			boost_q <= boost_d;
		end
	end

	// error flag sources on line A
	always_comb begin
		flagSet = errEventA;
		if (txStartA && cycleArmA && txQueueEmptyA) begin
			flagSet[cqcce_pkg::BIT_TX_CYCLE_EMPTY_FLAG_A] = 1'b1;
		end
		if (rxDoneA && rxCountA != rxExpectA) begin
			flagSet[cqcce_pkg::BIT_RX_LENGTH_FLAG_A] = 1'b1;
		end
		if (rxMsgDoneA && rxSumCalcA != rxSumRecvA) begin
			flagSet[cqcce_pkg::BIT_RX_SUM_FLAG_A] = 1'b1;
		end
		if (rxParityA) begin
			flagSet[cqcce_pkg::BIT_RX_PARITY_FLAG_A] = 1'b1;
		end
		// a set in the clearing read's cycle survives the clear
		flags_d = (rdErr ? 8'h00 : flags_q) | flagSet;
		parIrq_d = rxParityA;
	end

	// flag registers; writes never reach them
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			flags_q <= cqcce_pkg::RST_LINE_A_ERROR_FLAGS;
			parIrq_q <= 1'b0;
		end else begin
			flags_q <= flags_d;
			parIrq_q <= parIrq_d;
		end
	end

	// read mux; unmapped offsets answer zero
	always_comb begin
		rdWord = 8'h00;
		if (regAddr == cqcce_pkg::OFS_LINE_B_CONTROL) begin
			rdWord = {baud_q, wake_q == cqcce_pkg::WS_AUTO_PULSE || wake_q == cqcce_pkg::WS_AUTO_WAIT,
				wake_q == cqcce_pkg::WS_MANUAL_PULSE, txClr_q, rxClr_q, arm_q, send_q};
		end else if (regAddr == cqcce_pkg::OFS_LINE_A_ERROR_FLAGS) begin
			rdWord = flags_q;
		end
	end

	// answers queue here so a stalled consumer loses none
	cqcce_buf #(.WIDTH(8), .DEPTH(2)) u_rdBuf (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.inValid(regRdEn),
		.inReady(bufInReady),
		.inData(rdWord),
		.outValid(regRdValid),
		.outReady(regRdAck),
		.outData(regRdData)
	);

	assign regRdReady = bufInReady;
	assign wakePulseB = pulse_q;
	assign currentBoostB = boost_q;
	assign wakeDoneIrq = irq_q;
	assign txModeB = txMode_q;
	assign devicePeriodB = period_q;
	assign txQueueClearB = txClr_q;
	assign rxQueueClearB = rxClr_q;
	assign cycleTimerArmB = arm_q;
	assign cycleTimerRunB = run_q;
	assign cycleTimerStartB = start_q;
	assign sendStartB = send_q;
	assign rxErrIrqA = parIrq_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	AST_SEND_ONE_CYCLE: assert property (
		wrCtl && regWrData[0] |=> sendStartB && txModeB ##1 !sendStartB)
		else $error("send bit did not clear after one cycle");
	AST_AUTO_START: assert property (
		wrCtl && regWrData[5] && framerOnB && wake_q == cqcce_pkg::WS_IDLE
		|=> wakePulseB && currentBoostB)
		else $error("automatic sequence did not start");
	AST_BOOST_IN_PULSE: assert property (
		currentBoostB |-> wakePulseB && wake_q == cqcce_pkg::WS_AUTO_PULSE)
		else $error("boost outside automatic pulse");
	AST_SEQ_OK: assert property (
		wake_q == cqcce_pkg::WS_AUTO_WAIT && seqDoneB && seqOkB
		|=> wakeDoneIrq && baud_q == $past(seqRateB) && devicePeriodB == $past(seqPeriodB))
		else $error("success did not store rate or raise irq");
	AST_SEQ_FAIL: assert property (
		wake_q == cqcce_pkg::WS_AUTO_WAIT && seqDoneB && !seqOkB
		|=> wakeDoneIrq && baud_q == 2'h0 && wake_q == cqcce_pkg::WS_IDLE)
		else $error("failure did not clear rate");
	AST_ARM_STOPS: assert property (
		!cycleTimerArmB |-> !cycleTimerRunB && !cycleTimerStartB)
		else $error("timer runs while disarmed");
	AST_MANUAL_RX: assert property (
		wake_q == cqcce_pkg::WS_MANUAL_PULSE && cnt_q == '0
		|=> !wakePulseB && !txModeB ##1 !wakePulseB)
		else $error("manual pulse end left transmit on");
	AST_READ_CLEARS: assert property (
		rdErr && errEventA == 8'h00 && !rxParityA && !rxDoneA && !rxMsgDoneA && !txStartA
		|=> flags_q == 8'h00)
		else $error("flag read did not clear");
	AST_PARITY: assert property (
		rxParityA |=> rxErrIrqA && flags_q[0])
		else $error("parity error lost");
	AST_LENGTH: assert property (
		rxDoneA && rxCountA != rxExpectA |=> flags_q[2])
		else $error("length mismatch not flagged");

	COV_AUTO_OK: cover property (wake_q == cqcce_pkg::WS_AUTO_WAIT && seqDoneB && seqOkB);
	COV_MANUAL: cover property ($fell(wakePulseB) && wake_q == cqcce_pkg::WS_IDLE);
	COV_READ_FULL: cover property (regRdEn && !regRdReady);
endmodule : cqcce_top

// [design/cqcce_pkg.sv]
// package for the line B control and line A error flag registers
// assumes one 50 MHz clock and an 8-bit register port decoded elsewhere
package cqcce_pkg;
	// register offsets on the register port
	localparam logic [4:0] OFS_LINE_B_CONTROL = 5'h07;
	localparam logic [4:0] OFS_LINE_A_ERROR_FLAGS = 5'h08;
	// reset values
	localparam logic [7:0] RST_LINE_B_CONTROL = 8'h00;
	localparam logic [7:0] RST_LINE_A_ERROR_FLAGS = 8'h00;
	// line_b_control field positions
	localparam int BIT_BAUD_RATE_B_HIGH = 7;
	localparam int BIT_BAUD_RATE_B_LOW = 6;
	localparam int BIT_AUTO_WAKEUP_SEQ_B = 5;
	localparam int BIT_MANUAL_WAKE_PULSE_B = 4;
	localparam int BIT_TX_QUEUE_CLEAR_B = 3;
	localparam int BIT_RX_QUEUE_CLEAR_B = 2;
	localparam int BIT_CYCLE_TIMER_ARM_B = 1;
	localparam int BIT_SEND_MASTER_MSG_B = 0;
	// line_a_error_flags field positions
	localparam int BIT_TX_FAIL_FLAG_A = 7;
	localparam int BIT_TX_CYCLE_EMPTY_FLAG_A = 6;
	localparam int BIT_RX_SUM_FLAG_A = 3;
	localparam int BIT_RX_LENGTH_FLAG_A = 2;
	localparam int BIT_RX_FRAMING_FLAG_A = 1;
	localparam int BIT_RX_PARITY_FLAG_A = 0;
	// baud-rate field codes
	localparam logic [1:0] BAUD_DETECT_FAIL = 2'h0;
	localparam logic [1:0] BAUD_4K8 = 2'h1;
	localparam logic [1:0] BAUD_38K4 = 2'h2;
	localparam logic [1:0] BAUD_230K4 = 2'h3;
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int WAKE_PULSE_US = 80;
	localparam int WAKE_PULSE_CYC = WAKE_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int WAKE_CNT_W = 12;
	// wake-up sequencer states
	typedef enum logic [1:0] {
		WS_IDLE,
		WS_AUTO_PULSE,
		WS_AUTO_WAIT,
		WS_MANUAL_PULSE
	} cqcce_wake_t;
endpackage : cqcce_pkg

// [design/cqcce_buf.sv]
// small shift buffer carrying register read answers
// assumes producer and consumer on the same clock
`timescale 1ns/1ns
module cqcce_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	// head sits in entry 0 so outputs come straight from flops
	if (DEPTH < 2 || WIDTH < 1) begin : g_paramChk
		$error("cqcce_buf needs DEPTH >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];  // entries
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [DEPTH-1:0] vld_q;  // one valid per entry
	logic [DEPTH-1:0] vld_d;
	logic push;
	logic pop;
	logic placed;

	// ready is the last entry's emptiness: honest, no push-through when full
	assign push = inValid && !vld_q[DEPTH-1];
	assign pop = vld_q[0] && outReady;
	assign inReady = !vld_q[DEPTH-1];
	assign outValid = vld_q[0];
	assign outData = mem_q[0];

	// shift toward the head, then fill the first free slot
	always_comb begin
		placed = 1'b0;
		mem_d = mem_q;
		vld_d = vld_q;
		if (pop) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				mem_d[i] = mem_q[i + 1];
				vld_d[i] = vld_q[i + 1];
			end
			vld_d[DEPTH-1] = 1'b0;
		end
		for (int i = 0; i < DEPTH; i++) begin
			if (push && !placed && !vld_d[i]) begin
				mem_d[i] = inData;
				vld_d[i] = 1'b1;
				placed = 1'b1;
			end
		end
	end

	// storage registers
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			vld_q <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= '0;
			end
		end else begin
			vld_q <= vld_d;
			mem_q <= mem_d;
		end
	end
endmodule : cqcce_buf

// [sim/cqcce_dev_model.sv]
// far-side device model that answers the automatic wake-up sequence on line B
// assumes the sequencer raises currentBoostB only during its own wake pulse
`timescale 1ns/1ns
module cqcce_dev_model (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic currentBoostB,  // a boosted pulse marks an automatic request
	input wire logic answerOk,  // detection outcome chosen by the bench
	input wire logic [1:0] answerRate,
	input wire logic [7:0] answerPeriod,
	input wire logic [7:0] answerDelay,  // reply latency in cycles, 0 is prompt
	output logic seqDoneB,
	output logic seqOkB,
	output logic [1:0] seqRateB,
	output logic [7:0] seqPeriodB
);
	logic pend_q;  // pulse seen, answer still owed
	logic [7:0] wait_q;  // remaining reply latency
	// answer once the pulse has ended; once no answer is owed the result
	// lines toggle, so a design that samples them late picks up junk
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pend_q <= 1'b0;
			wait_q <= 8'h00;
			seqDoneB <= 1'b0;
			seqOkB <= 1'b0;
			seqRateB <= 2'h0;
			seqPeriodB <= 8'h00;
		end else begin
			seqDoneB <= 1'b0;
			if (currentBoostB) begin  // pulse still running
				pend_q <= 1'b1;
				wait_q <= answerDelay;
			end else if (pend_q && wait_q != 8'h00) begin  // slow reply
				wait_q <= wait_q - 8'h01;
			end else if (pend_q) begin  // result valid with the done pulse only
				pend_q <= 1'b0;
				seqDoneB <= 1'b1;
				seqOkB <= answerOk;
				seqRateB <= answerRate;
				seqPeriodB <= answerPeriod;
			end else begin  // released lines
				seqOkB <= ~seqOkB;
				seqRateB <= ~seqRateB;
				seqPeriodB <= ~seqPeriodB;
			end
		end
	end
endmodule : cqcce_dev_model

// [sim/tb_top.sv]
// self-checking bench for the line B control and line A error flag block
// assumes the device model stands behind the line B sequencer outputs
`timescale 1ns/1ns
module tb_top;
	logic clk_sys, arst_n, regWrEn, regRdEn, regRdAck, regRdReady, regRdValid;
	logic [4:0] regAddr;
	logic [7:0] regWrData, regRdData, seqPeriodB, devicePeriodB, errEventA;
	logic framerOnB, seqDoneB, seqOkB, txQueueEmptyB, triggerCmdB, wakePulseB;
	logic [1:0] seqRateB, answerRate;
	logic currentBoostB, wakeDoneIrq, txModeB, txQueueClearB, rxQueueClearB;
	logic cycleTimerArmB, cycleTimerRunB, cycleTimerStartB, sendStartB;
	logic cycleArmA, txStartA, txQueueEmptyA, rxDoneA, rxMsgDoneA, rxParityA, rxErrIrqA;
	logic [7:0] rxCountA, rxExpectA, answerPeriod, answerDelay;
	logic [5:0] rxSumCalcA, rxSumRecvA;
	logic answerOk;
	int miscompares = 0;
	int cmp_count = 0;
	int n;
	cqcce_top dut_u (.clk_sys, .arst_n, .regWrEn, .regRdEn, .regAddr, .regWrData,
		.regRdReady, .regRdValid, .regRdAck, .regRdData, .framerOnB, .seqDoneB,
		.seqOkB, .seqRateB, .seqPeriodB, .txQueueEmptyB, .triggerCmdB, .wakePulseB,
		.currentBoostB, .wakeDoneIrq, .txModeB, .devicePeriodB, .txQueueClearB,
		.rxQueueClearB, .cycleTimerArmB, .cycleTimerRunB, .cycleTimerStartB,
		.sendStartB, .errEventA, .cycleArmA, .txStartA, .txQueueEmptyA, .rxDoneA,
		.rxCountA, .rxExpectA, .rxMsgDoneA, .rxSumCalcA, .rxSumRecvA, .rxParityA,
		.rxErrIrqA);
	cqcce_dev_model dev_u (.clk_sys, .arst_n, .currentBoostB, .answerOk, .answerRate,
		.answerPeriod, .answerDelay, .seqDoneB, .seqOkB, .seqRateB, .seqPeriodB);
	// 50 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish
	// one compare for every byte or flag result, flags zero-extended
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// single-byte write, strobe high for exactly one rising edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge clk_sys);
		regWrEn = 1'b0;
	endtask : wr
	// read request held until an edge that sees regRdReady high
	task automatic issue(input logic [4:0] a);
		int k;
		k = 0;
		@(negedge clk_sys);
		regRdEn = 1'b1;
		regAddr = a;
		while (regRdReady !== 1'b1 && k < 50) begin
			@(negedge clk_sys);
			k++;
		end
		if (k >= 50) begin
			miscompares++;
			$display("[FAIL] %0t read request never taken", $time);
		end
		@(negedge clk_sys);
		regRdEn = 1'b0;
	endtask : issue
	// wait for the head answer, compare, then pop it with one ack edge
	task automatic get(input logic [7:0] exp);
		int k;
		k = 0;
		@(negedge clk_sys);
		while (regRdValid !== 1'b1 && k < 50) begin
			@(negedge clk_sys);
			k++;
		end
		chk({7'h00, regRdValid}, 8'h01);
		chk(regRdData, exp);
		regRdAck = 1'b1;
		@(negedge clk_sys);
		regRdAck = 1'b0;
	endtask : get
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		issue(a);
		get(exp);
	endtask : rd
	task automatic wait_irq;
		n = 0;
		while (wakeDoneIrq !== 1'b1 && n < 6000) begin
			@(negedge clk_sys);
			n++;
		end
	endtask : wait_irq
	// watchdog at 50k cycles, well beyond the roughly 20k the sequence needs
	initial begin
		#1_000_000;
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		tally_and_finish();
	end
	// main sequence: inputs change only at the falling edge
	initial begin
		{arst_n, regWrEn, regRdEn, regRdAck, framerOnB, txQueueEmptyB, triggerCmdB} = '0;
		{cycleArmA, txStartA, txQueueEmptyA, rxDoneA, rxMsgDoneA, rxParityA} = '0;
		{regAddr, regWrData, errEventA, rxCountA, rxExpectA} = '0;
		{rxSumCalcA, rxSumRecvA, answerOk, answerRate, answerPeriod, answerDelay} = '0;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		arst_n = 1'b1;
		// after reset only the read side is ready, every other output idle
		chk({regRdReady, regRdValid, wakePulseB, currentBoostB, wakeDoneIrq, txModeB, sendStartB,
			cycleTimerStartB}, 8'h80);
		rd(cqcce_pkg::OFS_LINE_B_CONTROL, cqcce_pkg::RST_LINE_B_CONTROL);
		rd(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS, 8'h00);
		rd(5'h1f, 8'h00);
		wr(5'h1f, 8'h02);
		rd(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h00);
		// derived error events, all mismatching, plus a direct one
		@(negedge clk_sys);
		{errEventA, rxParityA, cycleArmA, txStartA, txQueueEmptyA} = {8'h80, 4'hf};
		{rxDoneA, rxCountA, rxExpectA, rxMsgDoneA} = {1'b1, 8'h03, 8'h04, 1'b1};
		{rxSumCalcA, rxSumRecvA} = {6'h11, 6'h12};
		@(negedge clk_sys);
		{errEventA, rxParityA, txQueueEmptyA, rxDoneA, rxMsgDoneA} = '0;
		chk({7'h00, rxErrIrqA}, 8'h01);
		rd(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS, 8'hcd);
		// matching counts and sums set nothing; writes cannot touch flags
		@(negedge clk_sys);
		{errEventA, rxDoneA, rxExpectA, rxMsgDoneA, rxSumRecvA} = {8'h32, 1'b1, 8'h03, 1'b1, 6'h11};
		@(negedge clk_sys);
		{errEventA, rxDoneA, rxMsgDoneA, cycleArmA, txStartA} = '0;
		wr(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS, 8'hff);
		rd(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS, 8'h32);
		rd(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS, 8'h00);
		// queue clears are single pulses
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h08);
		chk({6'h00, txQueueClearB, rxQueueClearB}, 8'h02);
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h04);
		chk({6'h00, txQueueClearB, rxQueueClearB}, 8'h01);
		// arm, then send: timer starts, line turns round when queue empties
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h02);
		chk({6'h00, cycleTimerArmB, cycleTimerRunB}, 8'h02);
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h03);
		chk({5'h00, cycleTimerStartB, sendStartB, txModeB}, 8'h07);
		@(negedge clk_sys);
		chk({5'h00, cycleTimerStartB, cycleTimerRunB, txModeB}, 8'h03);
		txQueueEmptyB = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk({7'h00, txModeB}, 8'h00);
		rd(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h02);
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h00);
		chk({7'h00, cycleTimerRunB}, 8'h00);
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h02);
		triggerCmdB = 1'b1;
		@(negedge clk_sys);
		triggerCmdB = 1'b0;
		chk({6'h00, cycleTimerStartB, cycleTimerRunB}, 8'h03);
		@(negedge clk_sys);
		chk({6'h00, cycleTimerStartB, cycleTimerRunB}, 8'h01);
		// manual pulse with no automatic sequence; a zero write must not cut it
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h10);
		chk({6'h00, wakePulseB, currentBoostB}, 8'h02);
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h00);
		n = 0;
		while (wakePulseB === 1'b1 && n < 5000) begin
			n++;
			@(negedge clk_sys);
		end
		chk(8'(n), 8'(cqcce_pkg::WAKE_PULSE_CYC - 2));
		chk(8'(n >> 8), 8'((cqcce_pkg::WAKE_PULSE_CYC - 2) >> 8));
		chk({6'h00, txModeB, wakeDoneIrq}, 8'h00);
		rd(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h00);
		// automatic request refused while the framer is off
		wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h20);
		@(negedge clk_sys);
		chk({7'h00, wakePulseB}, 8'h00);
		framerOnB = 1'b1;
		// failure first, then every detected rate, prompt and slow replies
		for (int r = 0; r < 4; r++) begin
			answerOk = (r != 0);
			answerRate = (r == 0) ? 2'h3 : r[1:0];
			answerPeriod = 8'h50 + r[7:0];
			answerDelay = r[7:0] * 8'h07;
			wr(cqcce_pkg::OFS_LINE_B_CONTROL, 8'h20);
			chk({6'h00, wakePulseB, currentBoostB}, 8'h03);
			wait_irq();
			chk({7'h00, wakeDoneIrq}, 8'h01);
			rd(cqcce_pkg::OFS_LINE_B_CONTROL, {r[1:0], 6'h00});
			if (r > 0) begin
				chk(devicePeriodB, 8'h50 + r[7:0]);
			end
		end
		// two reads queue behind a stalled consumer and leave in order
		@(negedge clk_sys);
		errEventA = 8'h01;
		@(negedge clk_sys);
		errEventA = 8'h00;
		issue(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS);
		issue(cqcce_pkg::OFS_LINE_A_ERROR_FLAGS);
		chk({7'h00, regRdReady}, 8'h00);
		get(8'h01);
		get(8'h00);
		tally_and_finish();
	end
endmodule : tb_top
